// *** core/ddr_cmd_host.sv ***
// Decided for this implementation: the address map and the Wishbone slave port.
`default_nettype none
// Operation
// - commands encode as cs, ras, cas, we levels on a rising edge
// - refresh with gate high; gate falling enters self refresh; rise exits
// - all idle and gate falling on nop enters precharge power-down
// - bank open and gate falling enters active power-down
// - open only idle banks; read or write only open banks
// - burst stop only while a burst of 2, 4 or 8 runs; the code only requires some bank open
// - mode load only with all banks idle and gate high
// - wait two cycles after a mode load before next command
// - mode register has no reset value; must be programmed
// - undefined mode bits written zero; reserved codes avoided
// - program the smallest latency meeting access time
module ddr_cmd_host
	import ddr_cmd_pkg::*;
(
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        reset,
	// wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	// device command pins
	output logic             clk_gate,
	output logic             chip_sel_n,
	output logic             row_strobe_n,
	output logic             col_strobe_n,
	output logic             write_strobe_n,
	output logic [1:0]       group_select,
	output logic [12:0]      addr,
	output logic             low_byte_mask,
	output logic             high_byte_mask
);
	// ----------------------------------------------------------------
	// software registers
	// ----------------------------------------------------------------
	logic [3:0]  cmd_code;
	logic [14:0] cmd_addr;
	logic [1:0]  mask_reg;
	logic [14:0] mode_shadow;
	logic        mode_loaded;
	logic        go;
	logic [2:0]  gap;
	logic        pdown;
	logic        selfref;
	wire  [banks-1:0] bank_open; // one bit per tracker instance
	seq_t        state;
	seq_t        next_state;

	wire         bus_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire         wr_ctrl   = bus_req & wb_we_i & (wb_adr_i == reg_ctrl_off) & wb_sel_i[1];
	wire         wr_addr   = bus_req & wb_we_i & (wb_adr_i == reg_addr_off);
	wire         wr_mask   = bus_req & wb_we_i & (wb_adr_i == reg_mask_off);
	wire         all_idle  = ~|bank_open;
	wire [1:0]   bank      = cmd_addr[14:13];
	wire         cmd_a10   = cmd_addr[a10_bit];
	wire         bank_hit  = bank_open[bank];

	// legality check: refused commands simply complete with no pins moved
	op_t op;
	assign op = op_t'(cmd_code);
	wire asleep = pdown | selfref;
	wire legal =
		(op == op_open)       ? (~asleep & ~bank_hit) :
		(op == op_read)       ? (~asleep & bank_hit) :
		(op == op_write)      ? (~asleep & bank_hit) :
		(op == op_mode)       ? (~asleep & all_idle & (gap == 3'h0)) :
		(op == op_refresh)    ? (~asleep & all_idle) :
		(op == op_self_enter) ? (~asleep & all_idle) :
		(op == op_pdown)      ? ~asleep :
		(op == op_wake)       ? asleep :
		(op == op_stop)       ? (~asleep & |bank_open) :
		(op == op_close)      ? ~asleep :
		~asleep;

	// pin pattern for the current order
	wire [3:0] op_pins =
		(op == op_open)       ? pins_open :
		(op == op_close)      ? pins_close :
		(op == op_read)       ? pins_read :
		(op == op_write)      ? pins_write :
		(op == op_mode)       ? pins_mode :
		(op == op_refresh)    ? pins_refresh :
		(op == op_self_enter) ? pins_refresh :
		(op == op_stop)       ? pins_stop :
		pins_nop;
	// gate level in the command cycle; wake raises it on a nop
	wire gate_cmd = ~((op == op_self_enter) | (op == op_pdown));

	// ----------------------------------------------------------------
	// register writes
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			cmd_code <= 4'h0;
			cmd_addr <= 15'h0000;
			mask_reg <= 2'h0;
		end else begin
			if (wr_ctrl) cmd_code <= wb_dat_i[3:0];
			if (wr_addr) cmd_addr <= wb_dat_i[14:0];
			if (wr_mask) mask_reg <= wb_dat_i[1:0];
		end
	end

	// go is set by software, cleared by the sequencer when done
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			go <= 1'b0;
		end else if (wr_ctrl & wb_dat_i[go_bit]) begin
			go <= 1'b1;
		end else if (state == st_done) begin
			go <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// read mux and ack: registered, ack one cycle after the request
	// ----------------------------------------------------------------
	wire [31:0] status_word = {20'h00000, mode_loaded, selfref, pdown, go, bank_open, gap, 1'b0};
	wire [31:0] rd_mux =
		(wb_adr_i == reg_ctrl_off)   ? {23'h000000, go, 4'h0, cmd_code} :
		(wb_adr_i == reg_addr_off)   ? {17'h00000, cmd_addr} :
		(wb_adr_i == reg_mask_off)   ? {30'h00000000, mask_reg} :
		(wb_adr_i == reg_status_off) ? status_word :
		(wb_adr_i == reg_mode_off)   ? {17'h00000, mode_shadow} :
		unmapped_data;

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= bus_req;
			wb_dat_o <= rd_mux;
		end
	end

	// ----------------------------------------------------------------
	// sequencer: idle -> issue (one pin cycle) -> wait (gap) -> done
	// ----------------------------------------------------------------
	always_comb begin
		next_state = state;
		unique case (state)
			st_idle:  if (go) next_state = legal ? st_issue : st_done;
			st_issue: next_state = st_wait;
			st_wait:  if (gap <= 3'h1) next_state = st_done;
			st_done:  next_state = st_idle;
		endcase
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) state <= st_idle;
		else state <= next_state;
	end

	wire issuing = (state == st_issue);

	// gap counter holds off all commands after a mode load
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			gap <= 3'h0;
		end else if (issuing & (op == op_mode)) begin
			gap <= gap_count;
		end else if (gap != 3'h0) begin
			gap <= gap - 3'h1;
		end
	end

	// ----------------------------------------------------------------
	// pin drivers; deselect between commands
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			{chip_sel_n, row_strobe_n, col_strobe_n, write_strobe_n} <= pins_deselect;
			clk_gate       <= 1'b1;
			group_select   <= 2'h0;
			addr           <= 13'h0000;
			low_byte_mask  <= 1'b1;
			high_byte_mask <= 1'b1;
		end else if (issuing) begin
			{chip_sel_n, row_strobe_n, col_strobe_n, write_strobe_n} <= op_pins;
			clk_gate       <= gate_cmd;
			group_select   <= bank;
			addr           <= cmd_addr[12:0];
			low_byte_mask  <= ~(op == op_write) | mask_reg[0];
			high_byte_mask <= ~(op == op_write) | mask_reg[1];
		end else begin
			// deselect keeps other strobes irrelevant
			{chip_sel_n, row_strobe_n, col_strobe_n, write_strobe_n} <= pins_deselect;
			clk_gate       <= ~asleep;
		end
	end

	// ----------------------------------------------------------------
	// power state tracking
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			pdown   <= 1'b0;
			selfref <= 1'b0;
		end else if (issuing) begin
			if (op == op_pdown) pdown <= 1'b1;
			if (op == op_self_enter) selfref <= 1'b1;
			if (op == op_wake) begin
				pdown   <= 1'b0;
				selfref <= 1'b0;
			end
		end
	end

	// mode shadow: no value claimed until the first load
	// field codes and latency choice are software's; passed through unchanged
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			mode_loaded <= 1'b0;
			mode_shadow <= 15'h0000;
		end else if (issuing & (op == op_mode)) begin
			mode_loaded <= 1'b1;
			mode_shadow <= cmd_addr;
		end
	end

	// ----------------------------------------------------------------
	// per-bank open state; the controller closes at once on auto close
	// ----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < banks; gi++) begin : g_bank
			wire sel_me = (bank == 2'(gi));
			wire opn = issuing & (op == op_open) & sel_me;
			wire cls = issuing & ( ((op == op_close) & (cmd_a10 | sel_me))
				| (((op == op_read) | (op == op_write)) & cmd_a10 & sel_me));
			ddr_bank_track u_track (
				.clk      (ref_clk),
				.reset    (reset),
				.open_hit (opn),
				.close_hit(cls),
				.is_open  (bank_open[gi])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	mode_gap_a: assert property (@(posedge ref_clk) disable iff (reset)
		(issuing & (op == op_mode)) |=> !chip_sel_n ##1 (chip_sel_n & !issuing) [*2])
		else $error("command issued inside mode load gap");
	mode_idle_a: assert property (@(posedge ref_clk) disable iff (reset)
		(issuing & (op == op_mode)) |-> (all_idle & clk_gate))
		else $error("mode load with open bank or gate low");
	rw_open_a: assert property (@(posedge ref_clk) disable iff (reset)
		(issuing & ((op == op_read) | (op == op_write))) |-> bank_hit)
		else $error("read or write to idle bank");
	open_idle_a: assert property (@(posedge ref_clk) disable iff (reset)
		(issuing & (op == op_open)) |-> !bank_hit)
		else $error("open of an already open bank");
	gate_prior_a: assert property (@(posedge ref_clk) disable iff (reset)
		(issuing & (op != op_wake)) |-> clk_gate)
		else $error("command without gate high the cycle before");
	mode_pins_a: assert property (@(posedge ref_clk) disable iff (reset)
		(issuing & (op == op_mode)) |=> ({chip_sel_n, row_strobe_n, col_strobe_n, write_strobe_n} == pins_mode
			&& addr == $past(cmd_addr[12:0]))) else $error("mode load pins wrong");
	deselect_a: assert property (@(posedge ref_clk) disable iff (reset)
		!issuing |=> chip_sel_n) else $error("chip select low outside a command");
	mask_a: assert property (@(posedge ref_clk) disable iff (reset)
		(issuing & (op == op_write)) |=> (low_byte_mask == $past(mask_reg[0])
			&& high_byte_mask == $past(mask_reg[1]))) else $error("write byte mask wrong");
	// packed view of the strobes for the power-down, wake and self refresh checks
	wire [3:0] pin_word = {chip_sel_n, row_strobe_n, col_strobe_n, write_strobe_n};
	pdown_pins_a: assert property (@(posedge ref_clk) disable iff (reset)
		(issuing & (op == op_pdown)) |=> (!clk_gate && pin_word == pins_nop))
		else $error("power-down entry pins wrong");
	wake_gate_a: assert property (@(posedge ref_clk) disable iff (reset)
		(issuing & (op == op_wake)) |=> (clk_gate && pin_word == pins_nop))
		else $error("wake pins wrong");
	self_enter_a: assert property (@(posedge ref_clk) disable iff (reset)
		(issuing & (op == op_self_enter)) |=> (!clk_gate && pin_word == pins_refresh))
		else $error("self refresh entry pins wrong");
	stop_open_a: assert property (@(posedge ref_clk) disable iff (reset)
		(issuing & (op == op_stop)) |-> (|bank_open))
		else $error("burst stop with no open bank");
endmodule // ddr_cmd_host
`default_nettype wire

// *** pkg/ddr_cmd_pkg.sv ***
`default_nettype none
package ddr_cmd_pkg;
	// ----------------------------------------------------------------
	// wishbone register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] reg_ctrl_off   = 8'h00; // cmd code [3:0], go [8]
	localparam logic [7:0] reg_addr_off   = 8'h04; // addr [12:0], group [14:13]
	localparam logic [7:0] reg_mask_off   = 8'h08; // byte masks [1:0]
	localparam logic [7:0] reg_status_off = 8'h0C; // busy, banks open, mode state
	localparam logic [7:0] reg_mode_off   = 8'h10; // shadow of last mode load
	localparam int         go_bit         = 8;
	localparam logic [31:0] unmapped_data = 32'h0000_0000;

	// ----------------------------------------------------------------
	// commands software may ask for
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		op_nop        = 4'h0,
		op_open       = 4'h1,
		op_close      = 4'h2,
		op_read       = 4'h3,
		op_write      = 4'h4,
		op_mode       = 4'h5,
		op_refresh    = 4'h6,
		op_self_enter = 4'h7,
		op_pdown      = 4'h8,
		op_wake       = 4'h9,
		op_stop       = 4'hA
	} op_t;

	// ----------------------------------------------------------------
	// pin encodings {cs_n, ras_n, cas_n, we_n}
	// ----------------------------------------------------------------
	localparam logic [3:0] pins_deselect = 4'hF;
	localparam logic [3:0] pins_nop      = 4'h7;
	localparam logic [3:0] pins_open     = 4'h3;
	localparam logic [3:0] pins_close    = 4'h2;
	localparam logic [3:0] pins_read     = 4'h5;
	localparam logic [3:0] pins_write    = 4'h4;
	localparam logic [3:0] pins_mode     = 4'h0;
	localparam logic [3:0] pins_refresh  = 4'h1;
	localparam logic [3:0] pins_stop     = 4'h6;

	// ----------------------------------------------------------------
	// mode register fields and timing
	// ----------------------------------------------------------------
	localparam int         a10_bit       = 10;
	localparam int         bl_lsb        = 0;
	localparam int         order_bit     = 3;
	localparam int         lat_lsb       = 4;
	localparam int         test_lsb      = 7;
	localparam logic [2:0] bl_code_2     = 3'h1;
	localparam logic [2:0] bl_code_4     = 3'h2;
	localparam logic [2:0] bl_code_8     = 3'h3;
	localparam logic [2:0] lat_code_2    = 3'h2;
	localparam logic [2:0] lat_code_3    = 3'h3;
	localparam logic [2:0] lat_code_2p5  = 3'h6;
	localparam logic [1:0] test_normal   = 2'h0;
	localparam logic [1:0] test_dll_rst  = 2'h2;
	localparam int         mode_load_gap = 2;   // cycles after a mode load
	localparam logic [2:0] gap_count     = 3'(mode_load_gap);
	localparam int         banks         = 4;

	typedef enum logic [1:0] {
		st_idle  = 2'b00,
		st_issue = 2'b01,
		st_wait  = 2'b11,
		st_done  = 2'b10
	} seq_t;
endpackage
`default_nettype wire

// *** core/ddr_bank_track.sv ***
`default_nettype none
// ----------------------------------------------------------------
// one bank's open/idle view, as the controller drives it
// ----------------------------------------------------------------
module ddr_bank_track
	import ddr_cmd_pkg::*;
(
	// clock and reset
	input  wire logic clk,
	input  wire logic reset,
	// command events
	input  wire logic open_hit,
	input  wire logic close_hit,
	// state
	output logic      is_open
);
	// close wins: a close-all and an open never coincide on one edge
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			is_open <= 1'b0;
		end else if (close_hit) begin
			is_open <= 1'b0;
		end else if (open_hit) begin
			is_open <= 1'b1;
		end
	end
endmodule // ddr_bank_track
`default_nettype wire

// *** dv/ddr_dev_model.sv ***
`default_nettype none
// ----------------------------------------------------------------
// device side: decodes the pins the controller drives
// ----------------------------------------------------------------
module ddr_dev_model
	import ddr_cmd_pkg::*;
(
	// clock
	input  wire logic        clk,
	// command pins
	input  wire logic        clk_gate,
	input  wire logic        chip_sel_n,
	input  wire logic        row_strobe_n,
	input  wire logic        col_strobe_n,
	input  wire logic        write_strobe_n,
	input  wire logic [1:0]  group_select,
	input  wire logic [12:0] addr,
	input  wire logic        low_byte_mask,
	input  wire logic        high_byte_mask
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [14:0] mode_reg;          // left unknown until a load
	logic [12:0] ext_reg;
	logic [3:0]  bank_open = 4'h0;
	logic [1:0]  last_mask;
	logic        gate_q    = 1'b1;
	logic        selfref   = 1'b0;
	logic        pd_pre    = 1'b0;
	logic        pd_act    = 1'b0;
	int          burst     = 0;
	int          gap       = 100;
	int          cmd_cnt   = 0;
	int          wr_cnt    = 0;
	int          ref_cnt   = 0;
	int          stop_cnt  = 0;
	int          viol_cnt  = 0;
	// decode of pins and mode fields
	wire logic [3:0] pins      = {chip_sel_n, row_strobe_n, col_strobe_n, write_strobe_n};
	wire logic       idle_cmd  = chip_sel_n || pins == pins_nop;
	wire logic [3:0] burst_len = (mode_reg[2:0] == bl_code_2) ? 4'h2 : (mode_reg[2:0] == bl_code_4) ? 4'h4 :
		(mode_reg[2:0] == bl_code_8) ? 4'h8 : 4'h0;
	wire logic [2:0] lat_half  = (mode_reg[6:4] == lat_code_2) ? 3'h4 : (mode_reg[6:4] == lat_code_3) ? 3'h6 :
		(mode_reg[6:4] == lat_code_2p5) ? 3'h5 : 3'h0;
	wire logic       dll_rst   = mode_reg[8:7] == test_dll_rst;
	// column of beat i; wraps inside the aligned block
	function automatic logic [2:0] beat_col(input logic [2:0] col, input logic [2:0] i);
		logic [2:0] m;
		m = 3'(burst_len - 4'h1);
		return mode_reg[order_bit] ? (col ^ (i & m)) : ((col & ~m) | ((col + i) & m));
	endfunction
	// one command per edge; gate edges on idle cycles switch power states
	always @(posedge clk) begin
		gate_q <= clk_gate;
		gap <= gap + 1;
		burst <= (burst > 0) ? burst - 1 : 0;
		if (gate_q && !clk_gate && idle_cmd) begin
			pd_act <= |bank_open;
			pd_pre <= ~|bank_open;
		end
		if (!gate_q && clk_gate && idle_cmd) begin
			selfref <= 1'b0;
			pd_act <= 1'b0;
			pd_pre <= 1'b0;
		end
		if (!chip_sel_n && pins != pins_nop) begin
			cmd_cnt <= cmd_cnt + 1;
			if (!gate_q || gap < mode_load_gap)
				viol_cnt <= viol_cnt + 1;
			case (pins)
				pins_open: begin
					if (bank_open[group_select])
						viol_cnt <= viol_cnt + 1;
					bank_open[group_select] <= 1'b1;
				end
				pins_close: begin
					if (addr[a10_bit])
						bank_open <= 4'h0;
					else
						bank_open[group_select] <= 1'b0;
				end
				pins_read, pins_write: begin
					if (!bank_open[group_select])
						viol_cnt <= viol_cnt + 1;
					if (addr[a10_bit])
						bank_open[group_select] <= 1'b0;
					if (pins == pins_write)
						last_mask <= {high_byte_mask, low_byte_mask};
					wr_cnt <= wr_cnt + ((pins == pins_write) ? 1 : 0);
					burst <= int'(burst_len);
				end
				pins_mode: begin
					if (|bank_open || !clk_gate)
						viol_cnt <= viol_cnt + 1;
					else if (group_select[0])
						ext_reg <= addr;
					else
						mode_reg <= {group_select, addr};
					gap <= 1;
				end
				pins_refresh: begin
					if (clk_gate)
						ref_cnt <= ref_cnt + 1;
					else
						selfref <= 1'b1;
				end
				pins_stop: begin
					stop_cnt <= stop_cnt + 1;
					burst <= 0;
					if (burst == 0)
						viol_cnt <= viol_cnt + 1;
				end
				default: ;
			endcase
		end
	end
endmodule // ddr_dev_model
`default_nettype wire

// *** dv/testbench.sv ***
`default_nettype none
module testbench
	import ddr_cmd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic        ref_clk, reset, wb_cyc_i, wb_stb_i, wb_we_i;
	logic [7:0]  wb_adr_i;
	logic [31:0] wb_dat_i, wb_dat_o, q;
	logic        wb_ack_o, clk_gate, chip_sel_n, row_strobe_n, col_strobe_n, write_strobe_n;
	logic        low_byte_mask, high_byte_mask;
	logic [1:0]  group_select;
	logic [12:0] addr;
	int          miscompares = 0;
	int          cmp_count   = 0;
	logic [12:0] modes [4] = '{13'h0033, 13'h002A, 13'h0069, 13'h0122};
	logic [3:0]  bls   [4] = '{4'h8, 4'h4, 4'h2, 4'h4};
	logic [2:0]  lats  [4] = '{3'h6, 3'h4, 3'h5, 3'h4};
	logic [2:0]  wraps [4] = '{3'h0, 3'h6, 3'h6, 3'h4}; // beat 1 of a burst starting at column 7
	ddr_cmd_host uut (.ref_clk(ref_clk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .clk_gate(clk_gate), .chip_sel_n(chip_sel_n), .row_strobe_n(row_strobe_n),
		.col_strobe_n(col_strobe_n), .write_strobe_n(write_strobe_n), .group_select(group_select),
		.addr(addr), .low_byte_mask(low_byte_mask), .high_byte_mask(high_byte_mask));
	ddr_dev_model dev (.clk(ref_clk), .clk_gate(clk_gate), .chip_sel_n(chip_sel_n), .row_strobe_n(row_strobe_n),
		.col_strobe_n(col_strobe_n), .write_strobe_n(write_strobe_n), .group_select(group_select),
		.addr(addr), .low_byte_mask(low_byte_mask), .high_byte_mask(high_byte_mask));
	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// classic single cycle; held until ack is sampled high
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		int n;
		@(posedge ref_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		r = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		if (n >= 50)
			miscompares++;
	endtask
	// address, masks, then go; poll until go clears
	task automatic cmd(input op_t op, input logic [12:0] a, input logic [1:0] g, input logic [1:0] m);
		int n;
		wb(1'b1, reg_addr_off, {17'h0, g, a}, q);
		wb(1'b1, reg_mask_off, {30'h0, m}, q);
		wb(1'b1, reg_ctrl_off, 32'h0000_0100 | 32'(op), q);
		n = 0;
		do begin
			wb(1'b0, reg_status_off, 32'h0, q);
			n++;
		end while (q[go_bit] !== 1'b0 && n < 40);
		if (n >= 40)
			miscompares++;
	endtask
	task automatic conclude();
		if (miscompares == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// clock and watchdog
	// ----------------------------------------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	initial begin
		repeat (20000) @(posedge ref_clk);
		miscompares++;
		conclude();
	end
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	initial begin
		reset = 1'b1;
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
		repeat (12) @(posedge ref_clk);
		check("pins_in_reset", {clk_gate, chip_sel_n, row_strobe_n, col_strobe_n, write_strobe_n}, 5'h1F);
		check("masks_in_reset", {high_byte_mask, low_byte_mask}, 2'h3);
		reset <= 1'b0;
		wb(1'b1, 8'hF0, 32'hFFFF_FFFF, q);
		wb(1'b0, 8'hF0, 32'h0, q);
		check("unmapped_read", q, unmapped_data);
		// every length, ordering, latency and test code at least once
		for (int i = 0; i < 4; i++) begin
			cmd(op_mode, modes[i], 2'h0, 2'h3);
			check("mode_reg", dev.mode_reg, {2'h0, modes[i]});
			check("burst_len", dev.burst_len, bls[i]);
			check("lat_half", dev.lat_half, lats[i]);
			check("dll_rst", dev.dll_rst, i == 3);
			check("beat_order", dev.beat_col(3'h7, 3'h1), wraps[i]);
			wb(1'b0, reg_mode_off, 32'h0, q);
			check("mode_shadow", q[12:0], modes[i]);
		end
		cmd(op_mode, 13'h0001, 2'h1, 2'h3);
		check("ext_reg", dev.ext_reg, 13'h0001);
		check("base_kept", dev.mode_reg, {2'h0, modes[3]});
		cmd(op_mode, modes[0], 2'h0, 2'h3);
		// open, masked write, read with auto close
		cmd(op_open, 13'h0155, 2'h2, 2'h3);
		check("open_one", dev.bank_open, 4'h4);
		wb(1'b0, reg_status_off, 32'h0, q);
		check("status_open", q[7:4], 4'h4);
		cmd(op_write, 13'h0005, 2'h2, 2'h1);
		check("write_mask", {dev.wr_cnt[3:0], dev.last_mask}, 6'h05);
		cmd(op_read, 13'h0405, 2'h2, 2'h3);
		check("auto_close", dev.bank_open, 4'h0);
		cmd(op_read, 13'h0000, 2'h3, 2'h3);
		check("read_refused", dev.cmd_cnt, 32'd9);
		cmd(op_open, 13'h0000, 2'h0, 2'h3);
		cmd(op_open, 13'h0000, 2'h1, 2'h3);
		cmd(op_mode, 13'h0022, 2'h0, 2'h3);
		check("mode_refused", dev.mode_reg, {2'h0, modes[0]});
		cmd(op_close, 13'h0000, 2'h0, 2'h3);
		check("close_one", dev.bank_open, 4'h2);
		cmd(op_pdown, 13'h0000, 2'h0, 2'h3);
		wb(1'b0, reg_status_off, 32'h0, q);
		check("active_pdown", {dev.pd_act, dev.pd_pre, q[9]}, 3'h5);
		cmd(op_wake, 13'h0000, 2'h0, 2'h3);
		check("active_wake", {dev.pd_act, clk_gate}, 2'h1);
		cmd(op_close, 13'h0400, 2'h0, 2'h3);
		check("close_all", dev.bank_open, 4'h0);
		cmd(op_pdown, 13'h0000, 2'h0, 2'h3);
		check("idle_pdown", {dev.pd_act, dev.pd_pre}, 2'h1);
		cmd(op_wake, 13'h0000, 2'h0, 2'h3);
		check("idle_wake", dev.pd_pre, 1'b0);
		cmd(op_refresh, 13'h0000, 2'h0, 2'h3);
		check("auto_refresh", dev.ref_cnt, 32'd1);
		cmd(op_self_enter, 13'h0000, 2'h0, 2'h3);
		wb(1'b0, reg_status_off, 32'h0, q);
		check("self_enter", {dev.selfref, q[10], clk_gate}, 3'h6);
		cmd(op_wake, 13'h0000, 2'h0, 2'h3);
		check("self_exit", {dev.selfref, clk_gate}, 2'h1);
		cmd(op_stop, 13'h0000, 2'h0, 2'h3);
		check("stop_refused", dev.stop_cnt, 32'd0);
		check("pin_protocol", dev.viol_cnt, 32'd0);
		conclude();
	end
endmodule // testbench
`default_nettype wire
